//--- logic/ospm_pkg.sv
// Package: constants, object map and carrier types of the safe-state and mapping block
// Operation
// - A mailbox request is served before any other pending work, so a cyclic update waits behind it.
// - In buffered mode both sides share one data area; a master frame meeting a mailbox request is parked and written once the request ends.
// - Exchanges in both modes are arbitrated so that simultaneous accesses never tear shared data.
// - Cyclic communication with the master is supervised and an aborted exchange is detected.
// - Outside the operational state every output takes its substitute value instead of cyclic data.
// - Safe-state mode 00 forces outputs low (default), 01 high, 02 holds the last value, 03 uses a pattern.
// - The substitute pattern, one bit per output, is used only while the safe-state mode is 03.
// - Safe-state mode and pattern may be written only in pre-operational; other writes are refused.
// - The factory-reset request holds 00 for normal (default) or 01 for a request; other codes are reserved.
// - A pending factory-reset request acts only at the next device restart.
// - A 4-byte status word is placed in the transmitted cyclic image beside the input data.
// - The output receive mapping reads 5000 in bits 31-16, subindex 01 in bits 15-8 and length 8.
// - The input transmit mapping reads 4000 in bits 31-16, subindex 01 in bits 15-8 and length 8.
// - The status transmit mapping reads 4001 in bits 31-16, subindex 01 in bits 15-8 and length 32.
package ospm_pkg;

  // ----------------------------------------------------------------
  // Object indices and subindices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_RX_MAP     = 16'h1600;
  localparam logic [15:0] IDX_IN_MAP     = 16'h1a00;
  localparam logic [15:0] IDX_STAT_MAP   = 16'h1a01;
  localparam logic [15:0] IDX_SAFE_MODE  = 16'h2100;
  localparam logic [15:0] IDX_SAFE_VALS  = 16'h2102;
  localparam logic [15:0] IDX_FACT_RESET = 16'h2f00;
  localparam logic [15:0] IDX_IN_OBJ     = 16'h4000;
  localparam logic [15:0] IDX_STAT_OBJ   = 16'h4001;
  localparam logic [15:0] IDX_OUT_OBJ    = 16'h5000;
  localparam logic [7:0]  SUB_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_ENTRY      = 8'h01;

  // ----------------------------------------------------------------
  // Mapping contents
  // ----------------------------------------------------------------
  localparam logic [7:0]  LEN_BYTE       = 8'h08;
  localparam logic [7:0]  LEN_STATUS     = 8'h20;
  localparam logic [7:0]  CNT_IO_MAP     = 8'h02;
  localparam logic [7:0]  CNT_STAT_MAP   = 8'h01;
  localparam logic [7:0]  CNT_SAFE_VALS  = 8'h01;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  FR_NORMAL      = 8'h00;
  localparam logic [7:0]  FR_REQUEST     = 8'h01;
  localparam logic [7:0]  SAFE_RST       = 8'h00;

  typedef enum logic [7:0] {
    SAFE_LOW     = 8'h00,
    SAFE_HIGH    = 8'h01,
    SAFE_HOLD    = 8'h02,
    SAFE_PATTERN = 8'h03
  } ospm_safe_t;

  typedef enum logic [3:0] {
    AL_INIT   = 4'h1,
    AL_PREOP  = 4'h2,
    AL_BOOT   = 4'h3,
    AL_SAFEOP = 4'h4,
    AL_OP     = 4'h8
  } ospm_al_t;

  // ----------------------------------------------------------------
  // Supervision timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ       = 10000;
  localparam int unsigned WDOG_TIME_MS  = 100;
  localparam int unsigned WDOG_CYC_DEF  = WDOG_TIME_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subIndex;
    logic [31:0] wdata;
  } ospm_mbx_req_t;

  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [31:0] rdata;
  } ospm_mbx_rsp_t;

  typedef struct packed {
    logic [31:0] status;
    logic [7:0]  inputs;
  } ospm_tx_image_t;

endpackage

//--- logic/ospm_watchdog.sv
// Module: supervision of the cyclic exchange with the master
module ospm_watchdog
  import ospm_pkg::*;
#(
  parameter int unsigned CYCLES = WDOG_CYC_DEF
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Supervision
  input  wire logic armed,
  input  wire logic kick,
  output logic      expired
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  logic [CW-1:0] count_q;

  // Idle counter, restarted by every cyclic frame
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (!armed || kick) begin
      count_q <= '0;
    end else if (count_q != LIMIT) begin
      count_q <= count_q + CW'(1);
    end
  end

  // Failure flag; a fresh frame clears it so a recovered link resumes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      expired <= 1'b0;
    end else if (!armed || kick) begin
      expired <= 1'b0;
    end else if (count_q == LIMIT) begin
      expired <= 1'b1;
    end
  end

endmodule

//--- logic/ospm_top.sv
// Module: safe-state output handling, mapping objects and mailbox object access
module ospm_top
  import ospm_pkg::*;
#(
  parameter int unsigned NUM_OUT     = 4,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC_DEF
) (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           sys_rst,
  // Fieldbus state and restart
  input  wire logic [3:0]     alState,
  input  wire logic           devRestart,
  // Cyclic exchange
  input  wire logic           cycValid,
  input  wire logic [7:0]     cycOutData,
  input  wire logic [7:0]     inData,
  input  wire logic [31:0]    ioStatus,
  // Mailbox object access
  input  wire ospm_mbx_req_t  mbxReq,
  output ospm_mbx_rsp_t       mbxRsp,
  // Process image and outputs
  output ospm_tx_image_t      txImage,
  output logic                txValid,
  output logic [NUM_OUT-1:0]  digOut,
  // Status
  output logic                commFail,
  output logic                factoryResetDo,
  output logic                factoryResetPend
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Builds a mapping entry word: index, subindex, bit length
  // All three mapping objects use this layout
  function automatic logic [31:0] mapEntry(
    input logic [15:0] idx,
    input logic [7:0]  sub,
    input logic [7:0]  len
  );
    mapEntry = {idx, sub, len};
  endfunction

  // True when a written word fits an 8-bit code not above the limit
  // Shared by both code objects so their checks cannot drift apart
  function automatic logic codeFits(
    input logic [31:0] wd,
    input logic [7:0]  maxCode
  );
    codeFits = (wd[31:8] == 24'h000000) && (wd[7:0] <= maxCode);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Stored configuration
  ospm_safe_t          safeMode_q;
  logic [NUM_OUT-1:0]  pattern_q;
  logic [7:0]          factReq_q;

  // Shared output area and parked frame
  logic [7:0]          outBuf_q;
  logic                cycPend_q;
  logic [7:0]          cycData_q;

  // Registers behind the ports
  ospm_mbx_rsp_t       rsp_q;
  ospm_tx_image_t      tx_q;
  logic                txValid_q;
  logic [NUM_OUT-1:0]  digOut_q;
  logic                resetDo_q;

  // Supervision result
  logic                wdogExpired;

  // Decode of the current request
  logic                known;
  logic                writable;
  logic                preopOnly;
  logic                codeOk;
  logic [31:0]         rdData;

  // Access decision
  logic                refuse;
  logic                wrAccept;

  // Output selection
  logic                applyCyc;
  logic [7:0]          applyData;
  logic                runMode;
  logic [NUM_OUT-1:0]  safeVec;

  // ----------------------------------------------------------------
  // Supervision of the cyclic exchange
  // ----------------------------------------------------------------

  // Armed only in operational; frames are watched as they arrive,
  // not after the mailbox deferral, so a busy mailbox cannot fake a loss
  ospm_watchdog #(
    .CYCLES (WDOG_CYCLES)
  ) uWatchdog (
    .clock   (clock),
    .sys_rst (sys_rst),
    .armed   (alState == AL_OP),
    .kick    (cycValid),
    .expired (wdogExpired)
  );

  // ----------------------------------------------------------------
  // Mailbox object decode
  // ----------------------------------------------------------------

  // Read data and access rights of the addressed object
  always_comb begin
    known     = 1'b0;
    writable  = 1'b0;
    preopOnly = 1'b0;
    codeOk    = 1'b1;
    rdData    = '0;
    case (mbxReq.index)
      // Mapping objects: fixed words, never written
      IDX_RX_MAP: begin
        if (mbxReq.subIndex == SUB_COUNT) begin
          known  = 1'b1;
          rdData = {24'h000000, CNT_IO_MAP};
        end else if (mbxReq.subIndex == SUB_ENTRY) begin
          known  = 1'b1;
          rdData = mapEntry(IDX_OUT_OBJ, SUB_ENTRY, LEN_BYTE);
        end
      end
      IDX_IN_MAP: begin
        if (mbxReq.subIndex == SUB_COUNT) begin
          known  = 1'b1;
          rdData = {24'h000000, CNT_IO_MAP};
        end else if (mbxReq.subIndex == SUB_ENTRY) begin
          known  = 1'b1;
          rdData = mapEntry(IDX_IN_OBJ, SUB_ENTRY, LEN_BYTE);
        end
      end
      IDX_STAT_MAP: begin
        if (mbxReq.subIndex == SUB_COUNT) begin
          known  = 1'b1;
          rdData = {24'h000000, CNT_STAT_MAP};
        end else if (mbxReq.subIndex == SUB_ENTRY) begin
          known  = 1'b1;
          rdData = mapEntry(IDX_STAT_OBJ, SUB_ENTRY, LEN_STATUS);
        end
      end
      // Safe-state mode, a single-subindex object
      IDX_SAFE_MODE: begin
        if (mbxReq.subIndex == SUB_COUNT) begin
          known     = 1'b1;
          writable  = 1'b1;
          preopOnly = 1'b1;
          rdData    = {24'h000000, safeMode_q};
          codeOk    = codeFits(mbxReq.wdata, SAFE_PATTERN);
        end
      end
      // Substitute pattern; its count is read-only
      IDX_SAFE_VALS: begin
        if (mbxReq.subIndex == SUB_COUNT) begin
          known  = 1'b1;
          rdData = {24'h000000, CNT_SAFE_VALS};
        end else if (mbxReq.subIndex == SUB_ENTRY) begin
          known     = 1'b1;
          writable  = 1'b1;
          preopOnly = 1'b1;
          rdData    = {{(32 - NUM_OUT){1'b0}}, pattern_q};
          codeOk    = (mbxReq.wdata[31:8] == 24'h000000);
        end
      end
      // Factory-reset request, writable in any state
      IDX_FACT_RESET: begin
        if (mbxReq.subIndex == SUB_COUNT) begin
          known    = 1'b1;
          writable = 1'b1;
          rdData   = {24'h000000, factReq_q};
          codeOk   = codeFits(mbxReq.wdata, FR_REQUEST);
        end
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // Refusal: unknown object, read-only target, wrong state or bad code
  assign refuse = !known
                || (mbxReq.write && !writable)
                || (mbxReq.write && preopOnly && (alState != AL_PREOP))
                || (mbxReq.write && !codeOk);

  // Only accepted writes reach the stored objects;
  // a refused one leaves every stored object untouched
  assign wrAccept = mbxReq.valid && mbxReq.write && !refuse;

  // Mailbox answer, one cycle after the request
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= mbxReq.valid;
      rsp_q.abort <= mbxReq.valid && refuse;
      rsp_q.rdata <= (mbxReq.valid && !mbxReq.write && !refuse) ? rdData : '0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration objects
  // ----------------------------------------------------------------

  // Safe-state mode; the stored code is always one of the four legal ones
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      safeMode_q <= SAFE_LOW;
    end else if (wrAccept && (mbxReq.index == IDX_SAFE_MODE)) begin
      safeMode_q <= ospm_safe_t'(mbxReq.wdata[7:0]);
    end
  end

  // Substitute pattern, one bit per output
  // Bits above the output count up to bit 7 are dropped and read back as 0; a write with any of bits 31-8 set is refused
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pattern_q <= '0;
    end else if (wrAccept && (mbxReq.index == IDX_SAFE_VALS)) begin
      pattern_q <= mbxReq.wdata[NUM_OUT-1:0];
    end
  end

  // Factory-reset request: consumed by a restart, never acted on at once.
  // A write in the restart cycle still lands, so it is not lost.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      factReq_q <= FR_NORMAL;
      resetDo_q <= 1'b0;
    end else begin
      resetDo_q <= devRestart && (factReq_q == FR_REQUEST);
      if (devRestart) begin
        factReq_q <= FR_NORMAL;
      end
      if (wrAccept && (mbxReq.index == IDX_FACT_RESET)) begin
        factReq_q <= mbxReq.wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffered cyclic exchange
  // ----------------------------------------------------------------

  // A frame meeting a mailbox request is parked and applied afterwards;
  // only the newest parked frame is kept since older data is stale
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cycPend_q <= 1'b0;
      cycData_q <= '0;
    end else if (mbxReq.valid) begin
      if (cycValid) begin
        cycPend_q <= 1'b1;
        cycData_q <= cycOutData;
      end
    end else begin
      cycPend_q <= 1'b0;
    end
  end

  // Frames go through only in cycles free of mailbox work
  assign applyCyc  = !mbxReq.valid && (cycValid || cycPend_q);

  // A live frame is newer than a parked one
  assign applyData = cycValid ? cycOutData : cycData_q;

  // Shared output area: the master's frame is taken whole in one edge,
  // so the device side never sees half old, half new data
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      outBuf_q <= '0;
    end else if (applyCyc) begin
      outBuf_q <= applyData;
    end
  end

  // Transmitted image: inputs plus the status word, captured atomically
  // Both halves come from one edge, so they always belong together
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q      <= '0;
      txValid_q <= 1'b0;
    end else begin
      txValid_q <= applyCyc;
      if (applyCyc) begin
        tx_q.inputs <= inData;
        tx_q.status <= ioStatus;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------

  // Cyclic data drives the pins only in a healthy operational state
  assign runMode = (alState == AL_OP) && !wdogExpired;

  // Substitute value per output
  // An unknown mode code falls back to low, the safe level
  for (genvar i = 0; i < NUM_OUT; i++) begin : gSafe
    always_comb begin
      case (safeMode_q)
        SAFE_LOW:     safeVec[i] = 1'b0;
        SAFE_HIGH:    safeVec[i] = 1'b1;
        SAFE_HOLD:    safeVec[i] = digOut_q[i];
        SAFE_PATTERN: safeVec[i] = pattern_q[i];
        default:      safeVec[i] = 1'b0;
      endcase
    end
  end

  // Output register; holds are taken from its own value, so mode 02
  // freezes whatever was on the pins when the link dropped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      digOut_q <= '0;
    end else if (runMode) begin
      digOut_q <= outBuf_q[NUM_OUT-1:0];
    end else begin
      digOut_q <= safeVec;
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  // Every port is a register output
  assign mbxRsp           = rsp_q;
  assign txImage          = tx_q;
  assign txValid          = txValid_q;
  assign digOut           = digOut_q;
  assign commFail         = wdogExpired;
  assign factoryResetDo   = resetDo_q;
  assign factoryResetPend = factReq_q[0];

endmodule

//--- verif/ospm_top_monitor.sv
// Checker: port-level properties of the safe-state and mapping block
module ospm_top_monitor
  import ospm_pkg::*;
#(
  parameter int unsigned NUM_OUT     = 4,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC_DEF
) (
  // Clock and reset
  input wire logic               clock,
  input wire logic               sys_rst,
  // Watched ports
  input wire logic [3:0]         alState,
  input wire logic               devRestart,
  input wire logic               cycValid,
  input wire logic [7:0]         cycOutData,
  input wire logic [7:0]         inData,
  input wire logic [31:0]        ioStatus,
  input wire ospm_mbx_req_t      mbxReq,
  input wire ospm_mbx_rsp_t      mbxRsp,
  input wire ospm_tx_image_t     txImage,
  input wire logic               txValid,
  input wire logic [NUM_OUT-1:0] digOut,
  input wire logic               commFail,
  input wire logic               factoryResetDo,
  input wire logic               factoryResetPend
);
  // ----
  // Idle counter
  // ----
  logic [31:0] idleCnt_q;

  // Idle cycles in op since the last frame; two cycles of slack for arming
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idleCnt_q <= 32'h0;
    end else if (cycValid || alState != AL_OP) begin
      idleCnt_q <= 32'h0;
    end else begin
      idleCnt_q <= idleCnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ----
  // Properties
  // ----
  mbx_answer_a: assert property (mbxRsp.valid == $past(mbxReq.valid))
    else $error("mailbox answer not one cycle after request");
  mbx_first_a: assert property (mbxReq.valid |=> !txValid)
    else $error("frame applied beside a mailbox request");
  frame_image_a: assert property (cycValid && !mbxReq.valid |=> txValid && txImage == {$past(ioStatus), $past(inData)})
    else $error("transmit image wrong after frame");
  out_map_a: assert property (mbxReq.valid && !mbxReq.write && mbxReq.index == 16'h1600 && mbxReq.subIndex == 8'h01
    |=> mbxRsp.rdata == 32'h50000108 && !mbxRsp.abort)
    else $error("output mapping entry wrong");
  map_ro_a: assert property (mbxReq.valid && mbxReq.write && (mbxReq.index == 16'h1600 || mbxReq.index[15:8] == 8'h1a)
    |=> mbxRsp.abort)
    else $error("mapping write not refused");
  cfg_lock_a: assert property (mbxReq.valid && mbxReq.write && mbxReq.index == 16'h2100 && alState != AL_PREOP
    |=> mbxRsp.abort)
    else $error("mode write outside preop accepted");
  code_refuse_a: assert property (mbxReq.valid && mbxReq.write && mbxReq.index == 16'h2f00 && mbxReq.wdata > 32'h1
    && !devRestart |=> mbxRsp.abort && $stable(factoryResetPend))
    else $error("reserved reset code accepted");
  restart_do_a: assert property (devRestart && factoryResetPend && !mbxReq.valid
    |=> factoryResetDo && !factoryResetPend)
    else $error("restart did not execute request");
  wdog_early_a: assert property (idleCnt_q > 32'h2 && idleCnt_q < WDOG_CYCLES |-> !commFail)
    else $error("comm failure flagged early");
  wdog_late_a: assert property (idleCnt_q > WDOG_CYCLES + 2 && alState == AL_OP |-> commFail)
    else $error("comm failure not flagged");
  subst_stable_a: assert property ((!mbxReq.valid && !devRestart && alState != AL_OP) [*2] ##1 alState != AL_OP
    |=> $stable(digOut))
    else $error("outputs moved in substitute state");
  run_follow_a: assert property (alState == AL_OP && !commFail && cycValid && !mbxReq.valid
    ##1 alState == AL_OP && !commFail |=> digOut == $past(cycOutData[NUM_OUT-1:0], 2))
    else $error("outputs do not follow frame");
endmodule

bind ospm_top ospm_top_monitor #(.NUM_OUT(NUM_OUT), .WDOG_CYCLES(WDOG_CYCLES)) u_ospm_top_monitor (
  .clock(clock), .sys_rst(sys_rst), .alState(alState), .devRestart(devRestart), .cycValid(cycValid),
  .cycOutData(cycOutData), .inData(inData), .ioStatus(ioStatus), .mbxReq(mbxReq), .mbxRsp(mbxRsp),
  .txImage(txImage), .txValid(txValid), .digOut(digOut), .commFail(commFail),
  .factoryResetDo(factoryResetDo), .factoryResetPend(factoryResetPend)
);

//--- verif/ospm_master_model.sv
// Partner model: fieldbus master issuing mailbox requests and cyclic frames
module ospm_master_model
  import ospm_pkg::*;
(
  // Clock
  input  wire logic          clock,
  // Master side
  output ospm_mbx_req_t      mbxReq,
  input  wire ospm_mbx_rsp_t mbxRsp,
  output logic               cycValid,
  output logic [7:0]         cycOutData
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle at time zero
  initial begin
    mbxReq = '0;
    cycValid = 1'b0;
    cycOutData = 8'h00;
  end

  // One request, optionally with a frame in the same cycle; released fields are inverted
  task automatic mbx(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                     input logic frm, input logic [7:0] fd, output ospm_mbx_rsp_t rsp);
    @(posedge clock);
    #10;
    mbxReq = '{1'b1, wr, idx, sub, wd};
    cycValid = frm;
    cycOutData = fd;
    @(posedge clock);
    #10;
    rsp = mbxRsp;
    mbxReq = '{1'b0, ~wr, ~idx, ~sub, ~wd};
    cycValid = 1'b0;
    cycOutData = ~fd;
  endtask

  // One cyclic frame; the data line does not keep its last value afterwards
  task automatic frame(input logic [7:0] d);
    @(posedge clock);
    #10;
    cycValid = 1'b1;
    cycOutData = d;
    @(posedge clock);
    #10;
    cycValid = 1'b0;
    cycOutData = ~d;
  endtask
endmodule

//--- verif/ospm_top_tb_top.sv
// Testbench: mapping objects, safe-state outputs, supervision and factory reset
module ospm_top_tb_top
  import ospm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned WDOG = 20;
  localparam logic [15:0] MI [9] = '{16'h1600, 16'h1600, 16'h1a00, 16'h1a00, 16'h1a01, 16'h1a01, 16'h2100,
                                      16'h2102, 16'h2f00};
  localparam logic [7:0]  MS [9] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] ME [9] = '{32'h2, 32'h50000108, 32'h2, 32'h40000108, 32'h1, 32'h40010120, 32'h0,
                                      32'h1, 32'h0};
  localparam logic [7:0]  MODES [4] = '{8'h01, 8'h02, 8'h03, 8'h00};

  logic           clock;
  logic           sys_rst;
  logic           devRestart;
  logic           cycValid;
  logic           txValid;
  logic           commFail;
  logic           factoryResetDo;
  logic           factoryResetPend;
  logic [3:0]     alState;
  logic [3:0]     digOut;
  logic [3:0]     pat;
  logic [3:0]     last;
  logic [7:0]     cycOutData;
  logic [7:0]     inData;
  logic [7:0]     d;
  logic [31:0]    ioStatus;
  ospm_mbx_req_t  mbxReq;
  ospm_mbx_rsp_t  mbxRsp;
  ospm_mbx_rsp_t  rsp;
  ospm_tx_image_t txImage;
  int             miscompares = 0;
  int             checks = 0;
  int             cycles = 0;
  int             seed;

  ospm_top #(.WDOG_CYCLES(WDOG)) u_ospm_top (
    .clock(clock), .sys_rst(sys_rst), .alState(alState), .devRestart(devRestart), .cycValid(cycValid),
    .cycOutData(cycOutData), .inData(inData), .ioStatus(ioStatus), .mbxReq(mbxReq), .mbxRsp(mbxRsp),
    .txImage(txImage), .txValid(txValid), .digOut(digOut), .commFail(commFail),
    .factoryResetDo(factoryResetDo), .factoryResetPend(factoryResetPend)
  );

  ospm_master_model u_ospm_master_model (
    .clock(clock), .mbxReq(mbxReq), .mbxRsp(mbxRsp), .cycValid(cycValid), .cycOutData(cycOutData)
  );

  // ----
  // Clock and hang guard
  // ----
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // The whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      $display("ERROR run_length expected finish seen hang");
      tally_and_finish();
    end
  end

  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    u_ospm_master_model.mbx(wr, idx, sub, wd, 1'b0, 8'h00, rsp);
    chk("answer valid", rsp.valid, 32'h1);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  // Substitute value chosen by the safe-state mode
  function automatic logic [3:0] subst(input logic [7:0] m, input logic [3:0] p, input logic [3:0] l);
    case (m)
      8'h00: return 4'h0;
      8'h01: return 4'hf;
      8'h02: return l;
      default: return p;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 32'hf8df;
    sys_rst = 1'b1;
    alState = AL_INIT;
    devRestart = 1'b0;
    inData = 8'h00;
    ioStatus = 32'h0;
    repeat (8) @(posedge clock);
    #10;
    sys_rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, MI[i], MS[i], 32'h0);
      chk("object read", rsp.rdata, ME[i]);
      acc(1'b1, MI[i], 8'h01, $random(seed));
      chk("read-only write", rsp.abort, 32'h1);
    end
    acc(1'b0, 16'h3000, 8'h00, 32'h0);
    chk("unmapped abort", rsp.abort, 32'h1);
    acc(1'b1, 16'h2100, 8'h00, 32'h1);
    chk("init lock", rsp.abort, 32'h1);
    $display("test mapping done");
    alState = AL_PREOP;
    pat = 4'($random(seed));
    acc(1'b1, 16'h2102, 8'h01, {28'h0, pat});
    chk("pattern write", rsp.abort, 32'h0);
    last = 4'h0;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 16'h2100, 8'h00, {24'h0, MODES[i]});
      settle(2);
      last = subst(MODES[i], pat, last);
      chk("substitute", digOut, last);
      acc(1'b0, 16'h2100, 8'h00, 32'h0);
      chk("mode read", rsp.rdata, {24'h0, MODES[i]});
    end
    acc(1'b1, 16'h2100, 8'h00, 32'h4);
    chk("reserved mode", rsp.abort, 32'h1);
    acc(1'b1, 16'h2100, 8'h00, 32'h3);
    $display("test safe modes done");
    alState = AL_OP;
    repeat (12) begin
      d = 8'($random(seed));
      inData = 8'($random(seed));
      ioStatus = $random(seed);
      u_ospm_master_model.frame(d);
      chk("tx status", txImage.status, ioStatus);
      chk("tx inputs", {txImage.inputs, txValid}, {inData, 1'b1});
      settle(1);
      chk("run output", digOut, d[3:0]);
    end
    d = 8'($random(seed));
    u_ospm_master_model.mbx(1'b1, 16'h2100, 8'h00, 32'h1, 1'b1, d, rsp);
    chk("op lock", {rsp.abort, txValid}, 32'h2);
    settle(1);
    chk("parked frame", txValid, 32'h1);
    settle(1);
    chk("parked output", digOut, d[3:0]);
    alState = AL_SAFEOP;
    settle(2);
    chk("safeop output", digOut, pat);
    alState = AL_OP;
    u_ospm_master_model.frame(d);
    settle(1);
    chk("resume output", digOut, d[3:0]);
    settle(WDOG + 4);
    chk("watchdog", {commFail, digOut}, {1'b1, pat});
    u_ospm_master_model.frame(~d);
    settle(1);
    chk("watchdog clear", {commFail, digOut}, {1'b0, ~d[3:0]});
    $display("test cyclic done");
    alState = AL_SAFEOP;
    acc(1'b1, 16'h2f00, 8'h00, 32'h2);
    chk("reserved reset", {rsp.abort, factoryResetPend}, 32'h2);
    acc(1'b1, 16'h2f00, 8'h00, 32'h1);
    settle(1);
    chk("reset pending", {rsp.abort, factoryResetPend, factoryResetDo}, 32'h2);
    devRestart = 1'b1;
    settle(1);
    devRestart = 1'b0;
    chk("reset done", {factoryResetDo, factoryResetPend}, 32'h2);
    sys_rst = 1'b1;
    settle(1);
    sys_rst = 1'b0;
    acc(1'b0, 16'h2100, 8'h00, 32'h0);
    chk("mode after reset", rsp.rdata, 32'h0);
    $display("test factory reset done");
    tally_and_finish();
  end
endmodule
